//--- logic/tbc_pkg.sv
// Shared constants and types for the trace buffer capture block.
package tbc_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int TBC_ADDR_W = 18;
  localparam int TBC_LINE_W = 20;
  localparam int TBC_DEPTH = 64;
  localparam int TBC_PTR_W = 6;
  localparam int TBC_CNT_W = 7;
  localparam logic [6:0] TBC_LINES_FULL = 7'h40;
  localparam int TBC_PAGE_LSB = 6;
  localparam int TBC_GRP_W = 6;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam int TBC_AXI_AW = 8;
  localparam logic [7:0] TBC_OFF_CTRL = 8'h00;
  localparam logic [7:0] TBC_OFF_STAT = 8'h04;
  localparam logic [7:0] TBC_OFF_WIN_HI = 8'h08;
  localparam logic [7:0] TBC_OFF_WIN_LO = 8'h0C;
  localparam int TBC_CTRL_MODE_LSB = 0;
  localparam int TBC_CTRL_SRC_BIT = 2;
  localparam int TBC_CTRL_ALIGN_BIT = 3;
  localparam int TBC_CTRL_W = 4;
  localparam logic [3:0] TBC_CTRL_RST = 4'h0;
  localparam logic [1:0] TBC_RESP_OKAY = 2'h0;
  localparam logic [1:0] TBC_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Modes, classes, states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_LOOP = 2'h1,
    MODE_DETAIL = 2'h2,
    MODE_CPC = 2'h3
  } tbc_mode_e;

  typedef enum logic [2:0] {
    COF_NONE = 3'h0,
    COF_COND_TAKEN = 3'h1,
    COF_INDEXED = 3'h2,
    COF_RETURN = 3'h3,
    COF_VECTOR = 3'h4,
    COF_UNCOUNTED = 3'h5
  } tbc_cof_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN = 3'b100
  } tbc_state_e;

  localparam logic [1:0] CPC_BASE = 2'h0;
  localparam logic [1:0] CPC_ONE = 2'h1;
  localparam logic [1:0] CPC_TWO = 2'h2;
  localparam logic [1:0] CPC_THREE = 2'h3;

endpackage

//--- logic/tbc_trace_ram.sv
// Trace line memory with two write ports and one asynchronous read port.
`timescale 1ns/100ps
module tbc_trace_ram #(
  parameter int DEPTH = 64,
  parameter int LINE_W = 20,
  parameter int PTR_W = 6
) (
  input wire logic clk,
  input wire logic we_a,
  input wire logic [PTR_W-1:0] addr_a,
  input wire logic [LINE_W-1:0] data_a,
  input wire logic we_b,
  input wire logic [PTR_W-1:0] addr_b,
  input wire logic [LINE_W-1:0] data_b,
  input wire logic [PTR_W-1:0] rd_addr,
  output logic [LINE_W-1:0] rd_data
);

  logic [LINE_W-1:0] mem [DEPTH];

  // Port b always addresses the line after port a, so the two never collide.
  always_ff @(posedge clk) begin
    if (we_a) begin
      mem[addr_a] <= data_a;
    end
    if (we_b) begin
      mem[addr_b] <= data_b;
    end
  end

  assign rd_data = mem[rd_addr];

endmodule

//--- logic/tbc_top.sv
// Trace buffer capture block with its AXI4-Lite register slave.
`timescale 1ns/100ps

module tbc_top
  import tbc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  // AXI4-Lite slave.
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [TBC_AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [TBC_AXI_AW-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Debug state sequencer.
  input wire logic seq_arm,
  input wire logic seq_disarm,
  input wire logic seq_final,
  // Processor core.
  input wire logic background_debug_state,
  input wire logic cof_valid,
  input wire logic [2:0] cof_class,
  input wire logic cof_debug_vector,
  input wire logic [TBC_ADDR_W-1:0] cof_addr,
  input wire logic exec_valid,
  input wire logic [TBC_ADDR_W-1:0] exec_pc,
  input wire logic bus_valid,
  input wire logic bus_free,
  input wire logic bus_opfetch,
  input wire logic access_size_flag,
  input wire logic read_write_flag,
  input wire logic [TBC_ADDR_W-1:0] bus_addr,
  input wire logic [7:0] bus_data_even,
  input wire logic [7:0] bus_data_odd,
  // Status to the system.
  output logic trace_armed,
  output logic brk_req
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [TBC_AXI_AW-1:0] a);
    is_mapped = (a == TBC_OFF_CTRL) || (a == TBC_OFF_STAT) ||
                (a == TBC_OFF_WIN_HI) || (a == TBC_OFF_WIN_LO);
  endfunction

  function automatic logic [TBC_LINE_W-1:0] cpc_flush(input logic [1:0] n,
      input logic [TBC_GRP_W-1:0] g0, input logic [TBC_GRP_W-1:0] g1);
    cpc_flush = (n == 2'h2) ? {CPC_TWO, 6'h00, g1, g0} : {CPC_ONE, 6'h00, 6'h00, g0};
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  tbc_state_e state_q, state_d;
  logic [TBC_CTRL_W-1:0] trace_control_register_q;
  logic [TBC_PTR_W-1:0] wr_ptr_q, rd_ptr_q;
  logic [TBC_CNT_W-1:0] trace_line_counter_q;
  logic wrap_q;
  logic [TBC_ADDR_W-1:0] shadow_q;
  logic shadow_vld_q;
  logic [TBC_ADDR_W-TBC_PAGE_LSB-1:0] base_q;
  logic base_vld_q;
  logic [1:0] grp_cnt_q;
  logic [TBC_GRP_W-1:0] grp0_q, grp1_q;
  logic [TBC_LINE_W-1:0] line_a, line_b, rd_line;
  logic [1:0] n_lines;
  logic store_en, session_end, brk_d, cpc_new_page;
  logic [TBC_CNT_W-1:0] ptr_sum, cnt_sum, lines_left;
  tbc_mode_e trace_mode_select;
  logic trace_source_enable, align_begin;

  assign trace_mode_select = tbc_mode_e'(trace_control_register_q[TBC_CTRL_MODE_LSB +: 2]);
  assign trace_source_enable = trace_control_register_q[TBC_CTRL_SRC_BIT];
  assign align_begin = trace_control_register_q[TBC_CTRL_ALIGN_BIT];
  assign cpc_new_page = !base_vld_q || (exec_pc[TBC_ADDR_W-1:TBC_PAGE_LSB] != base_q);
  assign lines_left = TBC_LINES_FULL - trace_line_counter_q;

  // ----------------------------------------------------------------
  // Session sequencing
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    session_end = 1'b0;
    brk_d = 1'b0;
    // Storing is gated by source enable and suspended in background debug.
    store_en = trace_source_enable && !background_debug_state;
    case (state_q)
      ST_IDLE: begin
        store_en = 1'b0;
        if (seq_arm) begin
          state_d = align_begin ? ST_WAIT : ST_RUN;
        end
      end
      ST_WAIT: begin
        // Nothing is stored until the trigger; the trigger cycle itself is stored.
        store_en = store_en && seq_final;
        if (seq_final && !trace_source_enable) begin
          state_d = ST_IDLE;
          session_end = 1'b1;
          brk_d = 1'b1;
        end else if (seq_final) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!align_begin && seq_final) begin
          store_en = 1'b0;
          state_d = ST_IDLE;
          session_end = 1'b1;
          brk_d = 1'b1;
        end else if (align_begin && store_en && (n_lines >= lines_left[1:0]) &&
                     (lines_left <= TBC_CNT_W'(2)) && (n_lines != 2'h0)) begin
          state_d = ST_IDLE;
          session_end = 1'b1;
          brk_d = 1'b1;
        end
      end
      default: begin
        state_d = ST_IDLE;
        store_en = 1'b0;
      end
    endcase
    if (seq_disarm && state_q != ST_IDLE) begin
      state_d = ST_IDLE;
      session_end = 1'b1;
      brk_d = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Line formatting
  // ----------------------------------------------------------------
  always_comb begin
    line_a = '0;
    line_b = '0;
    n_lines = 2'h0;
    case (trace_mode_select)
      MODE_NORMAL, MODE_LOOP: begin
        if (cof_valid) begin
          case (tbc_cof_e'(cof_class))
            COF_COND_TAKEN: begin
              line_a = {1'b0, 1'b0, cof_addr};
              if (!(trace_mode_select == MODE_LOOP && shadow_vld_q && cof_addr == shadow_q)) begin
                n_lines = 2'h1;
              end
            end
            COF_INDEXED, COF_RETURN: begin
              // Stored at completion, whether or not an interrupt follows.
              line_a = {1'b1, 1'b0, cof_addr};
              n_lines = 2'h1;
            end
            COF_VECTOR: begin
              line_a = {1'b1, 1'b1, cof_addr};
              n_lines = cof_debug_vector ? 2'h0 : 2'h1;
            end
            default: begin
              n_lines = 2'h0;
            end
          endcase
        end
      end
      MODE_DETAIL: begin
        if (bus_valid && !bus_free && !bus_opfetch) begin
          line_a = {access_size_flag, read_write_flag, bus_addr};
          if (access_size_flag) begin
            line_b = {4'h0, 8'h00, bus_data_even};
          end else begin
            line_b = {4'h0, bus_data_even, bus_data_odd};
          end
          n_lines = 2'h2;
        end
      end
      MODE_CPC: begin
        if (exec_valid) begin
          if (cpc_new_page && grp_cnt_q != 2'h0) begin
            line_a = cpc_flush(grp_cnt_q, grp0_q, grp1_q);
            line_b = {CPC_BASE, exec_pc};
            n_lines = 2'h2;
          end else if (cpc_new_page) begin
            line_a = {CPC_BASE, exec_pc};
            n_lines = 2'h1;
          end else if (grp_cnt_q == 2'h2) begin
            line_a = {CPC_THREE, exec_pc[TBC_GRP_W-1:0], grp1_q, grp0_q};
            n_lines = 2'h1;
          end
        end
      end
      default: begin
        n_lines = 2'h0;
      end
    endcase
    if (!store_en) begin
      n_lines = 2'h0;
    end else if (align_begin && lines_left == TBC_CNT_W'(1) && n_lines == 2'h2) begin
      n_lines = 2'h1;
    end
  end

  assign ptr_sum = {1'b0, wr_ptr_q} + {5'h00, n_lines};
  assign cnt_sum = trace_line_counter_q + {5'h00, n_lines};

  // ----------------------------------------------------------------
  // Trace store and pointers
  // ----------------------------------------------------------------
  tbc_trace_ram #(
    .DEPTH(TBC_DEPTH),
    .LINE_W(TBC_LINE_W),
    .PTR_W(TBC_PTR_W)
  ) u_ram (
    .clk(clk),
    .we_a(n_lines != 2'h0),
    .addr_a(wr_ptr_q),
    .data_a(line_a),
    .we_b(n_lines == 2'h2),
    .addr_b(wr_ptr_q + TBC_PTR_W'(1)),
    .data_b(line_b),
    .rd_addr(rd_ptr_q),
    .rd_data(rd_line)
  );

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      trace_armed <= 1'b0;
      brk_req <= 1'b0;
    end else begin
      state_q <= state_d;
      trace_armed <= (state_d != ST_IDLE);
      brk_req <= brk_d;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_q <= '0;
      trace_line_counter_q <= '0;
      wrap_q <= 1'b0;
    end else if (state_q == ST_IDLE && seq_arm) begin
      wr_ptr_q <= '0;
      trace_line_counter_q <= '0;
      wrap_q <= 1'b0;
    end else begin
      wr_ptr_q <= ptr_sum[TBC_PTR_W-1:0];
      trace_line_counter_q <= (cnt_sum > TBC_LINES_FULL) ? TBC_LINES_FULL : cnt_sum;
      if (ptr_sum[TBC_PTR_W]) begin
        wrap_q <= 1'b1;
      end
    end
  end

  // Loop filter shadow and compressed-mode page and group tracking.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shadow_q <= '0;
      shadow_vld_q <= 1'b0;
    end else if (state_q == ST_IDLE && seq_arm) begin
      shadow_vld_q <= 1'b0;
    end else if (n_lines != 2'h0 && trace_mode_select == MODE_LOOP) begin
      shadow_q <= cof_addr;
      shadow_vld_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      base_q <= '0;
      base_vld_q <= 1'b0;
      grp_cnt_q <= 2'h0;
      grp0_q <= '0;
      grp1_q <= '0;
    end else if (state_q == ST_IDLE && seq_arm) begin
      base_vld_q <= 1'b0;
      grp_cnt_q <= 2'h0;
    end else if (store_en && trace_mode_select == MODE_CPC && exec_valid) begin
      if (cpc_new_page) begin
        base_q <= exec_pc[TBC_ADDR_W-1:TBC_PAGE_LSB];
        base_vld_q <= 1'b1;
        grp_cnt_q <= 2'h0;
      end else if (grp_cnt_q == 2'h2) begin
        grp_cnt_q <= 2'h0;
      end else begin
        if (grp_cnt_q == 2'h0) begin
          grp0_q <= exec_pc[TBC_GRP_W-1:0];
        end else begin
          grp1_q <= exec_pc[TBC_GRP_W-1:0];
        end
        grp_cnt_q <= grp_cnt_q + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic aw_hold_q, w_hold_q, aw_hold_d, w_hold_d, bvalid_d, do_write;
  logic [TBC_AXI_AW-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign aw_hold_d = (aw_hold_q || (s_axi_awvalid && s_axi_awready)) && !do_write;
  assign w_hold_d = (w_hold_q || (s_axi_wvalid && s_axi_wready)) && !do_write;
  assign bvalid_d = do_write || (s_axi_bvalid && !s_axi_bready);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= TBC_RESP_OKAY;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      s_axi_awready <= !aw_hold_d && !bvalid_d;
      s_axi_wready <= !w_hold_d && !bvalid_d;
      s_axi_bvalid <= bvalid_d;
      if (do_write) begin
        s_axi_bresp <= is_mapped(aw_addr_q) ? TBC_RESP_OKAY : TBC_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      trace_control_register_q <= TBC_CTRL_RST;
    end else if (do_write && aw_addr_q == TBC_OFF_CTRL && w_strb_q[0]) begin
      trace_control_register_q <= w_data_q[TBC_CTRL_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel and readout window
  // ----------------------------------------------------------------
  logic ar_take, win_adv;

  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign win_adv = ar_take && s_axi_araddr == TBC_OFF_WIN_LO && state_q == ST_IDLE;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= TBC_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? TBC_RESP_OKAY : TBC_RESP_SLVERR;
      case (s_axi_araddr)
        TBC_OFF_CTRL: s_axi_rdata <= {28'h0000000, trace_control_register_q};
        TBC_OFF_STAT: s_axi_rdata <= {23'h000000, wrap_q, trace_armed, trace_line_counter_q};
        TBC_OFF_WIN_HI: begin
          s_axi_rdata <= (state_q == ST_IDLE) ? {28'h0000000, rd_line[19:16]} : 32'h00000000;
        end
        TBC_OFF_WIN_LO: begin
          s_axi_rdata <= (state_q == ST_IDLE) ? {16'h0000, rd_line[15:0]} : 32'h00000000;
        end
        default: s_axi_rdata <= 32'h00000000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // Readout starts at the oldest line once a session ends.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_ptr_q <= '0;
    end else if (session_end) begin
      rd_ptr_q <= (wrap_q || ptr_sum[TBC_PTR_W]) ? ptr_sum[TBC_PTR_W-1:0] : '0;
    end else if (win_adv) begin
      rd_ptr_q <= rd_ptr_q + TBC_PTR_W'(1);
    end
  end

endmodule

//--- tb/tbc_sva.sv
// Port checks for the trace buffer capture block and its bind.
`timescale 1ns/100ps
module tbc_sva (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic seq_arm,
  input wire logic seq_final,
  input wire logic trace_armed,
  input wire logic brk_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence resp_due;
    ##[1:3] s_axi_bvalid;
  endsequence
  wr_resp_a: assert property (wr_taken |-> resp_due)
    else $error("write response missing");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
  rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  arm_cause_a: assert property ($rose(trace_armed) |-> $past(seq_arm) || $past(seq_final))
    else $error("armed without request");
  brk_pulse_a: assert property (brk_req |=> !brk_req)
    else $error("breakpoint request too long");
  brk_end_a: assert property (brk_req |-> ##[0:1] !trace_armed)
    else $error("breakpoint while still armed");
endmodule
bind tbc_top tbc_sva i_sva (.*);

//--- tb/tbc_core_model.sv
// Core and sequencer model that feeds trace events into the capture block.
`timescale 1ns/100ps
module tbc_core_model
  import tbc_pkg::*;
(
  input wire logic clk,
  output logic seq_arm,
  output logic seq_disarm,
  output logic seq_final,
  output logic background_debug_state,
  output logic cof_valid,
  output logic [2:0] cof_class,
  output logic cof_debug_vector,
  output logic [TBC_ADDR_W-1:0] cof_addr,
  output logic exec_valid,
  output logic [TBC_ADDR_W-1:0] exec_pc,
  output logic bus_valid,
  output logic bus_free,
  output logic bus_opfetch,
  output logic access_size_flag,
  output logic read_write_flag,
  output logic [TBC_ADDR_W-1:0] bus_addr,
  output logic [7:0] bus_data_even,
  output logic [7:0] bus_data_odd
);
  initial begin
    {seq_arm, seq_disarm, seq_final, background_debug_state, cof_valid} = 5'h00;
    {cof_debug_vector, exec_valid, bus_valid, bus_free, bus_opfetch} = 5'h00;
    {access_size_flag, read_write_flag, cof_class, cof_addr, exec_pc} = '0;
    {bus_addr, bus_data_even, bus_data_odd} = '0;
  end
  task automatic arm(input logic dis);
    @(posedge clk);
    {seq_arm, seq_disarm} <= {!dis, dis};
    @(posedge clk);
    {seq_arm, seq_disarm} <= 2'h0;
  endtask
  // One event lasts one cycle; valids then drop to zero and address and data lines show the inverse value.
  task automatic ev(input logic b, f, ib, ex, input logic [2:0] k, input logic dv,
      input logic [17:0] a, input logic fr, op, sz, rw, input logic [7:0] e, o);
    @(posedge clk);
    {background_debug_state, seq_final, cof_valid, bus_valid, exec_valid} <= {b, f, !ib, ib, ex};
    {cof_class, cof_debug_vector, cof_addr, bus_addr, exec_pc} <= {k, dv, a, a, a};
    {bus_free, bus_opfetch, access_size_flag, read_write_flag} <= {fr, op, sz, rw};
    {bus_data_even, bus_data_odd} <= {e, o};
    @(posedge clk);
    {background_debug_state, seq_final, cof_valid, bus_valid, exec_valid} <= 5'h00;
    {cof_addr, bus_addr, exec_pc, bus_data_even, bus_data_odd} <= {~a, ~a, ~a, ~e, ~o};
  endtask
endmodule

//--- tb/tbc_top_tb_top.sv
// Self-checking bench for the trace buffer capture block.
`timescale 1ns/100ps
module tbc_top_tb_top;
  import tbc_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic trace_armed, brk_req, seq_arm, seq_disarm, seq_final, background_debug_state;
  logic cof_valid, cof_debug_vector, exec_valid, bus_valid, bus_free, bus_opfetch;
  logic access_size_flag, read_write_flag;
  logic [2:0] cof_class;
  logic [17:0] cof_addr, exec_pc, bus_addr;
  logic [7:0] bus_data_even, bus_data_odd;
  int miscompares = 0, tests_run = 0, brks = 0, seed = 48552;
  logic [19:0] q[$];
  logic [17:0] sh = 18'h0;
  logic cap = 1'b0, beg = 1'b0;
  logic [3:0] tab [9] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hC, 4'hE, 4'hF};
  always #2 clk = ~clk;
  always @(posedge clk) if (brk_req === 1'b1) brks++;
  tbc_top i_dut (.*);
  tbc_core_model i_core (.*);
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    {s_axi_awvalid, s_axi_wvalid, s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {2'h3, a, d, 4'hF};
    for (n = 0; n < 64; n++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 64) begin miscompares++; summarize(); end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    {s_axi_arvalid, s_axi_araddr} <= {1'b1, a};
    for (n = 0; n < 64; n++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
    if (n == 64) begin miscompares++; summarize(); end
  endtask
  // Model store: begin alignment closes the session at exactly 64 lines.
  task automatic put(input logic [19:0] l);
    if (cap) begin
      q.push_back(l);
      if (beg && q.size() == 64) cap = 1'b0;
    end
  endtask
  task automatic run(input logic [3:0] c);
    logic [31:0] d, h;
    logic [17:0] a;
    logic [7:0] e, o;
    logic [2:0] k;
    logic [11:0] bp;
    logic [5:0] g0, g1;
    logic [1:0] r, m, gc;
    logic b, f, ib, ex, bv, dv, fr, op, sz, rw;
    int i, n, b0;
    {m, beg} = {c[1:0], c[3]};
    {ex, bv, gc} = {m == MODE_CPC, 3'h0};
    wr(TBC_OFF_CTRL, {28'h0, c}, r);
    chk(r, TBC_RESP_OKAY);
    rd(TBC_OFF_CTRL, d, r);
    chk(d, {28'h0, c});
    q.delete();
    cap = !beg && c[2];
    b0 = brks;
    i_core.arm(1'b0);
    for (i = 0; i < 320; i++) begin
      f = beg && i == 3;
      a = ($random(seed) & 1) ? 18'h2A5C3 : 18'($random(seed));
      k = 3'({$random(seed)} % 6);
      {dv, fr, op, sz, rw, e, o} = 21'($random(seed));
      ib = m == MODE_DETAIL;
      b = ($random(seed) & 15) == 0;
      if (i == 0 || f) {k, b} = {3'h2, 1'b0};
      if (f) cap = c[2];
      i_core.ev(b, f, ib, ex, k, dv, a, fr, op, sz, rw, e, o);
      if (!b && ib && !fr && !op) begin
        put({sz, rw, a});
        put(sz ? {12'h0, e} : {4'h0, e, o});
      end
      if (!b && !ib && !ex && k inside {3'h1, 3'h2, 3'h3, 3'h4} && !(k == 3'h4 && dv)
          && !(m == MODE_LOOP && k == 3'h1 && a == sh)) begin
        if (cap) sh = a;
        put({k != 3'h1, k == 3'h4, a});
      end
      // Compressed model: base line on a new 64 byte page, else low bits in threes.
      if (!b && ex && cap) begin
        if (!bv || a[17:6] != bp) begin
          if (gc == 2'h1) put({2'h1, 12'h0, g0});
          if (gc == 2'h2) put({2'h2, 6'h0, g1, g0});
          put({2'h0, a});
          {bv, bp, gc} = {1'b1, a[17:6], 2'h0};
        end else if (gc == 2'h2) begin
          put({2'h3, a[5:0], g1, g0});
          gc = 2'h0;
        end else begin
          if (gc == 2'h0) g0 = a[5:0];
          else g1 = a[5:0];
          gc++;
        end
      end
      if (!beg && c[2] && i == 80) begin
        rd(TBC_OFF_WIN_LO, d, r);
        chk(d, 32'h0);
      end
    end
    if (!beg) i_core.ev(1'b0, 1'b1, 1'b0, ex, 3'h1, 1'b0, a, 1'b0, 1'b0, 1'b0, 1'b0, e, o);
    for (n = 0; n < 100 && trace_armed !== 1'b0; n++) @(posedge clk);
    if (n == 100) begin miscompares++; summarize(); end
    repeat (2) @(posedge clk);
    chk(brks - b0, 32'h1);
    rd(TBC_OFF_STAT, d, r);
    chk(d[7:0], q.size() > 64 ? 64 : q.size());
    while (q.size() > 64) void'(q.pop_front());
    for (i = 0; i < q.size(); i++) begin
      rd(TBC_OFF_WIN_HI, h, r);
      rd(TBC_OFF_WIN_LO, d, r);
      chk({h[15:0], d[15:0]}, {12'h0, q[i]});
    end
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int n0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd(TBC_OFF_CTRL, d, r);
    chk(d, {28'h0, TBC_CTRL_RST});
    rd(8'h10, d, r);
    chk(d, 32'h0);
    chk(r, TBC_RESP_SLVERR);
    wr(8'h10, 32'hF, r);
    chk(r, TBC_RESP_SLVERR);
    wr(TBC_OFF_STAT, 32'h1FF, r);
    chk(r, TBC_RESP_OKAY);
    foreach (tab[j]) run(tab[j]);
    // A disarm aborts the session without a breakpoint request.
    n0 = brks;
    i_core.arm(1'b0);
    @(posedge clk);
    chk(trace_armed, 32'h1);
    i_core.arm(1'b1);
    repeat (2) @(posedge clk);
    chk(trace_armed, 32'h0);
    chk(brks - n0, 32'h0);
    summarize();
  end
endmodule
